// File: apsl_core.sv
// alarm latching, acknowledge detection and status outputs of the analog remote socket
// assumes socket pins already synchronous to core_clk; rst also models a power cycle
// What this block does
// - Any alarm during analog remote control turns the dc output off.
// - Overvoltage, overcurrent and overpower alarms latch and keep the output off until acknowledged.
// - Acknowledge is standby high, then low for at least 50 ms, then high again, and nothing else.
// - The safety overvoltage alarm ignores acknowledge and clears only by power cycle.
// - A latched safety overvoltage raises the power-fail and the overvoltage indications together.
// - The select input low hands control to the socket, high or open keeps internal control.
// - The resistance-mode input low enables resistance mode, high or open disables it.
// - Alarm output one is high during overtemperature or power fail or while safety overvoltage is latched, else low.
// - Alarm output two is high while an overvoltage, overcurrent, overpower or safety overvoltage alarm is latched, else low.
// - Status is low under constant-voltage regulation and high under the other regulations.
// - In output-state mode status is low while the dc output is on and high while off.
// - Under analog remote control only the standby input decides the dc output, high requesting on.
// - A setup bit inverts the standby input meaning, default level and acknowledge polarity.
`default_nettype none
module apsl_core #(
    parameter int ACK_LOW_CYC = apsl_pkg::ACK_LOW_CYC
) (
    input wire logic core_clk,
    input wire logic rst,
    // apb slave
    input wire apsl_pkg::apsl_apb_req_s apbReq,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq,
    // socket pins
    input wire logic remoteSelN,
    input wire logic resModeSelN,
    input wire logic output_standby_in,
    output logic alarmOut1,
    output logic alarmOut2,
    output logic statusOut,
    // power stage side
    input wire apsl_pkg::apsl_alarm_s alarmIn,
    input wire logic constant_voltage_regulation,
    input wire logic localOnReq,
    output logic dcOutputOn,
    output logic remoteActive,
    output logic resistanceMode
);
    logic [apsl_pkg::CTRL_W-1:0] ctrl_r;
    logic [apsl_pkg::EV_W-1:0] irqStat_r;
    logic [apsl_pkg::EV_W-1:0] irqMask_r;
    logic [apsl_pkg::EV_W-1:0] events;
    logic [31:0] lowCnt_r;
    logic sbPrev_r;
    logic ovLatch_r;
    logic ocLatch_r;
    logic opLatch_r;
    logic sovLatch_r;
    logic ackDone_r;
    logic sbOnLvl;
    logic ackPulse;
    logic anyLatched;
    logic blockOn;
    logic onReq;
    logic apbAccess;
    logic wrEn;
    logic addrHit;
    logic [31:0] rdMux;

    // standby level in "on" terms; the invert bit flips both sense and ack polarity
    assign sbOnLvl = output_standby_in ^ ctrl_r[apsl_pkg::CTRL_SB_INV];

    // length of the current off phase, saturating so a long low never wraps
    always_ff @(posedge core_clk) begin
        if (rst) begin
            lowCnt_r <= 32'h0;
            sbPrev_r <= 1'b1;
        end else begin
            sbPrev_r <= sbOnLvl;
            if (sbOnLvl) begin
                lowCnt_r <= 32'h0;
            end else if (lowCnt_r < 32'(ACK_LOW_CYC)) begin
                lowCnt_r <= lowCnt_r + 32'h1;
            end
        end
    end

    // ack only on the return edge after a long enough off phase
    assign ackPulse = sbOnLvl && !sbPrev_r && (lowCnt_r >= 32'(ACK_LOW_CYC));

    // latched protections; set wins over ack, and a live condition is never cleared
    always_ff @(posedge core_clk) begin
        if (rst) begin
            ovLatch_r <= 1'b0;
            ocLatch_r <= 1'b0;
            opLatch_r <= 1'b0;
        end else begin
            ovLatch_r <= alarmIn.overvoltage_alarm || (ovLatch_r && !ackPulse);
            ocLatch_r <= alarmIn.overcurrent_alarm || (ocLatch_r && !ackPulse);
            opLatch_r <= alarmIn.overpower_alarm || (opLatch_r && !ackPulse);
        end
    end

    // safety overvoltage has no clear path besides reset (power cycle)
    always_ff @(posedge core_clk) begin
        if (rst) begin
            sovLatch_r <= 1'b0;
        end else if (alarmIn.safety_overvoltage_alarm) begin
            sovLatch_r <= 1'b1;
        end
    end

    assign anyLatched = ovLatch_r || ocLatch_r || opLatch_r || sovLatch_r;
    // live alarms also block, so an output never blips on for the cycle before latching
    assign blockOn = anyLatched || alarmIn.overvoltage_alarm || alarmIn.overcurrent_alarm
        || alarmIn.overpower_alarm || alarmIn.overtemperature_alarm
        || alarmIn.power_fail_alarm || alarmIn.safety_overvoltage_alarm;
    // remote: standby alone decides; local: standby acts as a lockout on the panel request
    assign onReq = remoteActive ? sbOnLvl : (localOnReq && sbOnLvl);

    // dc output enable and selection pins
    always_ff @(posedge core_clk) begin
        if (rst) begin
            dcOutputOn <= 1'b0;
            remoteActive <= 1'b0;
            resistanceMode <= 1'b0;
        end else begin
            dcOutputOn <= onReq && !blockOn;
            remoteActive <= !remoteSelN;
            resistanceMode <= !resModeSelN;
        end
    end

    // socket status pins; safety overvoltage drives both alarm groups at once
    always_ff @(posedge core_clk) begin
        if (rst) begin
            alarmOut1 <= 1'b0;
            alarmOut2 <= 1'b0;
            statusOut <= 1'b1;
        end else begin
            alarmOut1 <= alarmIn.overtemperature_alarm || alarmIn.power_fail_alarm
                || sovLatch_r;
            alarmOut2 <= ovLatch_r || ocLatch_r || opLatch_r || sovLatch_r;
            if (ctrl_r[apsl_pkg::CTRL_STAT_OUT]) begin
                statusOut <= !dcOutputOn;
            end else begin
                statusOut <= !constant_voltage_regulation;
            end
        end
    end

    // apb decode; one wait state so read data comes from a flip-flop
    assign apbAccess = apbReq.psel && apbReq.penable;
    assign wrEn = apbAccess && pready && apbReq.pwrite;
    always_comb begin
        addrHit = 1'b1;
        rdMux = 32'h0;
        if (apbReq.paddr == apsl_pkg::CTRL_OFS) begin
            rdMux[apsl_pkg::CTRL_W-1:0] = ctrl_r;
        end else if (apbReq.paddr == apsl_pkg::STATE_OFS) begin
            rdMux[9:0] = {resistanceMode, remoteActive, dcOutputOn, ovLatch_r, ocLatch_r,
                opLatch_r, sovLatch_r, alarmIn.overtemperature_alarm,
                alarmIn.power_fail_alarm, sbOnLvl};
        end else if (apbReq.paddr == apsl_pkg::IRQ_STAT_OFS) begin
            rdMux[apsl_pkg::EV_W-1:0] = irqStat_r;
        end else if (apbReq.paddr == apsl_pkg::IRQ_MASK_OFS) begin
            rdMux[apsl_pkg::EV_W-1:0] = irqMask_r;
        end else begin
            addrHit = 1'b0;
        end
    end

    // answer phase registers
    always_ff @(posedge core_clk) begin
        if (rst) begin
            pready <= 1'b0;
            prdata <= 32'h0;
            pslverr <= 1'b0;
        end else if (apbAccess && !pready) begin
            pready <= 1'b1;
            prdata <= apbReq.pwrite ? 32'h0 : rdMux;
            pslverr <= !addrHit;
        end else begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    // software controls; the mask shares the event layout
    always_ff @(posedge core_clk) begin
        if (rst) begin
            ctrl_r <= apsl_pkg::CTRL_RST;
            irqMask_r <= apsl_pkg::EV_RST;
        end else if (wrEn && apbReq.paddr == apsl_pkg::CTRL_OFS) begin
            ctrl_r <= apbReq.pwdata[apsl_pkg::CTRL_W-1:0];
        end else if (wrEn && apbReq.paddr == apsl_pkg::IRQ_MASK_OFS) begin
            irqMask_r <= apbReq.pwdata[apsl_pkg::EV_W-1:0];
        end
    end

    // rising edges of the alarm state and accepted acks
    always_ff @(posedge core_clk) begin
        if (rst) begin
            ackDone_r <= 1'b0;
        end else begin
            ackDone_r <= ackPulse;
        end
    end
    assign events[apsl_pkg::EV_OV] = alarmIn.overvoltage_alarm && !ovLatch_r;
    assign events[apsl_pkg::EV_OC] = alarmIn.overcurrent_alarm && !ocLatch_r;
    assign events[apsl_pkg::EV_OP] = alarmIn.overpower_alarm && !opLatch_r;
    assign events[apsl_pkg::EV_SOV] = alarmIn.safety_overvoltage_alarm && !sovLatch_r;
    assign events[apsl_pkg::EV_OT] = alarmIn.overtemperature_alarm && !alarmOut1;
    assign events[apsl_pkg::EV_PF] = alarmIn.power_fail_alarm && !alarmOut1;
    assign events[apsl_pkg::EV_ACK] = ackDone_r;

    // sticky status, write one to clear; a new event in the clear cycle survives
    always_ff @(posedge core_clk) begin
        if (rst) begin
            irqStat_r <= apsl_pkg::EV_RST;
            irq <= 1'b0;
        end else begin
            if (wrEn && apbReq.paddr == apsl_pkg::IRQ_STAT_OFS) begin
                irqStat_r <= (irqStat_r & ~apbReq.pwdata[apsl_pkg::EV_W-1:0]) | events;
            end else begin
                irqStat_r <= irqStat_r | events;
            end
            irq <= |(irqStat_r & irqMask_r);
        end
    end

    // checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    a_alarm_blocks_out: assert property (anyLatched |=> !dcOutputOn)
        else $error("dc output on while an alarm is latched");
    a_latch_holds: assert property (ovLatch_r && !ackPulse |=> ovLatch_r [*2] or ackPulse)
        else $error("overvoltage latch dropped without acknowledge");
    a_ack_low_len: assert property (ackPulse |-> $past(!sbOnLvl) && lowCnt_r >= 32'(ACK_LOW_CYC))
        else $error("acknowledge without a long enough off phase");
    a_ack_clears_gone: assert property (ackPulse && !alarmIn.overcurrent_alarm |=> !ocLatch_r)
        else $error("acknowledge failed to clear a vanished alarm");
    a_ack_keeps_live: assert property (ackPulse && alarmIn.overpower_alarm |=> opLatch_r)
        else $error("acknowledge cleared a persisting alarm");
    a_sov_sticky: assert property (sovLatch_r |=> sovLatch_r)
        else $error("safety overvoltage latch cleared");
    a_sov_both_pins: assert property (sovLatch_r |=> alarmOut1 && alarmOut2)
        else $error("safety overvoltage not on both alarm outputs");
    a_alarm1_pin: assert property (!rst |-> alarmOut1 == $past(alarmIn.overtemperature_alarm
        || alarmIn.power_fail_alarm || sovLatch_r))
        else $error("alarm output one wrong");
    a_remote_sb_on: assert property (remoteActive && sbOnLvl && !blockOn
        |=> dcOutputOn ##1 !remoteActive || dcOutputOn || !$past(sbOnLvl)
        || $past(blockOn))
        else $error("standby high did not turn the output on");
    a_remote_sel: assert property (!remoteSelN ##1 !remoteSelN |=> remoteActive)
        else $error("select low did not give the socket control");
    a_rmode_sel: assert property (resModeSelN |=> !resistanceMode)
        else $error("resistance mode on with input high");
    a_status_cv: assert property (!rst && !ctrl_r[apsl_pkg::CTRL_STAT_OUT] && constant_voltage_regulation
        && $stable(ctrl_r) |=> !statusOut)
        else $error("status not low under constant voltage");
    a_status_out: assert property (ctrl_r[apsl_pkg::CTRL_STAT_OUT] && dcOutputOn
        && $stable(ctrl_r) |=> !statusOut)
        else $error("status not low while output on");
    a_sb_invert: assert property ($changed(ctrl_r[apsl_pkg::CTRL_SB_INV]) && $stable(output_standby_in)
        |-> sbOnLvl != $past(sbOnLvl))
        else $error("invert bit did not flip standby sense");
endmodule : apsl_core
`default_nettype wire

// File: apsl_pkg.sv
// constants and carrier types for the analog port alarm/status logic
// assumes a 200 MHz core clock and a 32-bit APB register port
`default_nettype none
package apsl_pkg;
    // clock and acknowledge timing
    localparam int CLK_HZ = 200_000_000;
    localparam int ACK_LOW_MS = 50;
    localparam int ACK_LOW_CYC = ACK_LOW_MS * (CLK_HZ / 1000);
    // register byte offsets
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] STATE_OFS = 8'h04;
    localparam logic [7:0] IRQ_STAT_OFS = 8'h08;
    localparam logic [7:0] IRQ_MASK_OFS = 8'h0c;
    // control fields
    localparam int CTRL_SB_INV = 0;
    localparam int CTRL_STAT_OUT = 1;
    localparam int CTRL_W = 2;
    localparam logic [CTRL_W-1:0] CTRL_RST = 2'h0;
    // event bits, shared by status and mask
    localparam int EV_OV = 0;
    localparam int EV_OC = 1;
    localparam int EV_OP = 2;
    localparam int EV_SOV = 3;
    localparam int EV_OT = 4;
    localparam int EV_PF = 5;
    localparam int EV_ACK = 6;
    localparam int EV_W = 7;
    localparam logic [EV_W-1:0] EV_RST = 7'h00;
    // alarm conditions reported by the power stage
    typedef struct packed {
        logic overvoltage_alarm;
        logic overcurrent_alarm;
        logic overpower_alarm;
        logic overtemperature_alarm;
        logic power_fail_alarm;
        logic safety_overvoltage_alarm;
    } apsl_alarm_s;
    // apb request as seen by the slave
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } apsl_apb_req_s;
endpackage : apsl_pkg
`default_nettype wire

// File: apsl_ctl_model.sv
// behavioural model of the external controller on the analog socket
// assumes bench commands are levels sampled on core_clk rising edges
`default_nettype none
module apsl_ctl_model (
    input wire logic core_clk,
    input wire logic wantRemote,
    input wire logic wantRes,
    input wire logic standbyOn,
    input wire logic invert,
    input wire logic ackGo,
    input wire logic [3:0] lowCyc,
    output logic remoteSelN,
    output logic resModeSelN,
    output logic output_standby_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] lowLeft;
    // open contacts read high until the controller closes them
    initial begin
        remoteSelN = 1'h1;
        resModeSelN = 1'h1;
        output_standby_in = 1'h1;
        lowLeft = 4'h0;
    end
    // relays switch one cycle late, the slow side of a real controller
    always @(posedge core_clk) begin
        remoteSelN <= !wantRemote;
        resModeSelN <= !wantRes;
    end
    // ack pulse: off level for lowCyc cycles, then back to on level
    always @(posedge core_clk) begin
        if (lowLeft != 4'h0) begin
            lowLeft <= lowLeft - 4'h1;
            output_standby_in <= invert;
        end else if (ackGo) begin
            lowLeft <= lowCyc - 4'h1;
            output_standby_in <= invert;
        end else begin
            output_standby_in <= standbyOn ? !invert : invert;
        end
    end
endmodule : apsl_ctl_model
`default_nettype wire

// File: tb.sv
// self-checking bench for the analog socket alarm and status logic
// assumes the package and apsl_core are compiled first; ack length cut to 4 cycles
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk, rst, wantRemote, wantRes, standbyOn, invert, ackGo, localOnReq, cvReg;
    logic pready, pslverr, irq, remoteSelN, resModeSelN, standbyPin, err;
    logic alarmOut1, alarmOut2, statusOut, dcOutputOn, remoteActive, resistanceMode;
    logic [3:0] lowCyc;
    logic [31:0] prdata, rd;
    apsl_pkg::apsl_apb_req_s apbReq;
    apsl_pkg::apsl_alarm_s alarmIn, v;
    int mismatches, checks;
    // rows: {ot, pf, cv, remote, res} -> {alarmOut1, statusOut, remoteActive, resistanceMode}
    logic [4:0] rowIn [4] = '{5'h04, 5'h15, 5'h0a, 5'h03};
    logic [3:0] rowOut [4] = '{4'h0, 4'h9, 4'he, 4'h7};

    apsl_core #(.ACK_LOW_CYC(4)) uut (.core_clk(core_clk), .rst(rst), .apbReq(apbReq), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .irq(irq), .remoteSelN(remoteSelN), .resModeSelN(resModeSelN),
        .output_standby_in(standbyPin), .alarmOut1(alarmOut1), .alarmOut2(alarmOut2), .statusOut(statusOut),
        .alarmIn(alarmIn), .constant_voltage_regulation(cvReg), .localOnReq(localOnReq),
        .dcOutputOn(dcOutputOn), .remoteActive(remoteActive), .resistanceMode(resistanceMode));
    apsl_ctl_model partner (.core_clk(core_clk), .wantRemote(wantRemote), .wantRes(wantRes),
        .standbyOn(standbyOn), .invert(invert), .ackGo(ackGo), .lowCyc(lowCyc), .remoteSelN(remoteSelN),
        .resModeSelN(resModeSelN), .output_standby_in(standbyPin));

    // 200 MHz clock
    initial begin
        core_clk = 1'h0;
        forever #2.5 core_clk = ~core_clk;
    end

    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : stop_test

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
    endtask : cyc

    // settle past the edge so registered outputs are stable
    task automatic look(input int n);
        cyc(n);
        #1;
    endtask : look

    // one apb transfer; request held until pready is seen at an edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge core_clk);
        apbReq <= '{psel: 1'h1, penable: 1'h0, pwrite: wr, paddr: a, pwdata: d};
        @(posedge core_clk);
        apbReq.penable <= 1'h1;
        do begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'h1 && n < 16);
        if (pready !== 1'h1) begin
            mismatches++;
            stop_test();
        end
        rd = prdata;
        err = pslverr;
        apbReq <= '0;
    endtask : apb

    task automatic ack(input logic [3:0] n);
        cyc(1);
        lowCyc <= n;
        ackGo <= 1'h1;
        cyc(1);
        ackGo <= 1'h0;
        look(int'(n) + 8);
    endtask : ack

    // short alarm condition, gone again before the checks
    task automatic pulse(input apsl_pkg::apsl_alarm_s a);
        cyc(1);
        alarmIn <= a;
        cyc(3);
        alarmIn <= '0;
        look(3);
    endtask : pulse

    // hang guard
    initial begin
        cyc(20000);
        mismatches++;
        stop_test();
    end

    initial begin
        rst = 1'h1; apbReq = '0; alarmIn = '0; wantRemote = 1'h0; wantRes = 1'h0; standbyOn = 1'h1;
        invert = 1'h0; ackGo = 1'h0; lowCyc = 4'h4; localOnReq = 1'h0; cvReg = 1'h1;
        mismatches = 0;
        checks = 0;
        look(3);
        chk(statusOut, 1'h1);
        chk({alarmOut1, alarmOut2, dcOutputOn, pready, irq}, 5'h00);
        cyc(1);
        rst <= 1'h0;
        // register reset values, then an unmapped read
        foreach (rowIn[i]) begin
            apb(1'h0, 8'(i * 4), 32'h0);
            chk(rd, (i == 1) ? 32'h1 : 32'h0); // only the standby on-level reads high
            chk(err, 32'h0);
        end
        apb(1'h0, 8'h10, 32'h0);
        chk(rd, 32'h0);
        chk(err, 32'h1);
        // ordinary cases
        foreach (rowIn[i]) begin
            cyc(1);
            {alarmIn.overtemperature_alarm, alarmIn.power_fail_alarm, cvReg, wantRemote, wantRes} <= rowIn[i];
            look(4);
            chk({alarmOut1, statusOut, remoteActive, resistanceMode}, rowOut[i]);
        end
        cyc(1);
        alarmIn <= '0;
        wantRemote <= 1'h1;
        look(4);
        chk(dcOutputOn, 1'h1);
        cyc(1);
        standbyOn <= 1'h0;
        look(4);
        chk(dcOutputOn, 1'h0);
        cyc(1);
        standbyOn <= 1'h1;
        apb(1'h1, apsl_pkg::IRQ_MASK_OFS, 32'h1 << apsl_pkg::EV_OV);
        // each latching alarm: latch, clean ack; irq and refusals for overvoltage only
        for (int k = 0; k < 3; k++) begin
            v = '0;
            {v.overvoltage_alarm, v.overcurrent_alarm, v.overpower_alarm} = 3'h4 >> k;
            pulse(v);
            chk(alarmOut2, 1'h1);
            chk(dcOutputOn, 1'h0);
            if (k == 0) begin
                chk(irq, 1'h1);
                apb(1'h1, apsl_pkg::IRQ_STAT_OFS, 32'h1 << apsl_pkg::EV_OV);
                look(2);
                chk(irq, 1'h0);
                ack(4'h3);
                chk(alarmOut2, 1'h1);
                cyc(1);
                alarmIn <= v;
                ack(4'h4);
                chk(alarmOut2, 1'h1);
                cyc(1);
                alarmIn <= '0;
            end
            ack(4'h4);
            chk({alarmOut2, dcOutputOn}, 2'h1);
        end
        // inverted standby with status showing dc state
        apb(1'h1, apsl_pkg::CTRL_OFS, 32'h3);
        cyc(1);
        invert <= 1'h1;
        look(4);
        chk({dcOutputOn, statusOut}, 2'h2);
        cyc(1);
        standbyOn <= 1'h0;
        look(4);
        chk({dcOutputOn, statusOut}, 2'h1);
        cyc(1);
        standbyOn <= 1'h1;
        v = '0;
        v.overcurrent_alarm = 1'h1;
        pulse(v);
        ack(4'h4);
        chk(alarmOut2, 1'h0);
        // safety overvoltage survives ack, only reset clears it
        v = '0;
        v.safety_overvoltage_alarm = 1'h1;
        pulse(v);
        chk({alarmOut1, alarmOut2}, 2'h3);
        ack(4'h4);
        chk({alarmOut1, alarmOut2, dcOutputOn}, 3'h6);
        cyc(1);
        rst <= 1'h1;
        cyc(2);
        rst <= 1'h0;
        look(3);
        chk({alarmOut1, alarmOut2}, 2'h0);
        stop_test();
    end
endmodule : tb
`default_nettype wire
